// [core/psmc_consts.vh]
`ifndef PSMC_CONSTS_VH
`define PSMC_CONSTS_VH
`define PSMC_ADDR_CTRL     12'h000
`define PSMC_ADDR_STATUS   12'h004
`define PSMC_ADDR_CMD      12'h008
`define PSMC_ADDR_HCAP     12'h00c
`define PSMC_ADDR_ACAP     12'h010
`define PSMC_CTRL_SLOW     0
`define PSMC_CTRL_AWEN     1
`define PSMC_CTRL_TIMEBASE1_IRQ_ENABLE    2
`define PSMC_CTRL_OVERFLOW_IRQ_ENABLE    3
`define PSMC_CTRL_ATBIT0   4
`define PSMC_CTRL_CK0      5
`define PSMC_CTRL_WDGEN    6
`define PSMC_CTRL_LONGDLY  7
`define PSMC_CMD_WAIT      0
`define PSMC_CMD_HALT      1
`define PSMC_SLOW_DIV      32
`define PSMC_FAST_DIV      1
`define PSMC_STAB_SHORT    256
`define PSMC_STAB_LONG     4096
`define PSMC_PLL_START_NS  1000
`define PSMC_CLK_MHZ       100
`define PSMC_IRQ_N         14
`define PSMC_HCAP_RST      14'h101f
`define PSMC_ACAP_RST      14'h0a00
`endif

// [core/psmc_ctrl.v]
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "psmc_consts.vh"
module psmc_ctrl #(
  parameter integer STAB_LONG  = `PSMC_STAB_LONG,
  parameter integer STAB_SHORT = `PSMC_STAB_SHORT,
  parameter integer NIRQ       = `PSMC_IRQ_N
) (
  input  wire            pclk,          // Master clock
  input  wire            presetn,       // Async reset, low
  input  wire            clk_en,        // Freezes all state when low
  input  wire            psel,          // APB select
  input  wire            penable,       // APB enable
  input  wire            pwrite,        // APB direction
  input  wire [11:0]     paddr,         // APB address
  input  wire [31:0]     pwdata,        // APB write data
  output wire            pready,        // APB ready
  output wire            pslverr,       // APB error
  output reg  [31:0]     prdata,        // APB read data
  input  wire            wait_for_irq_instruction, // CPU executes wait
  input  wire            halt_instr,    // CPU executes halt
  input  wire [NIRQ-1:0] irq_pend,      // Pending interrupt sources, async
  input  wire            ext_reset_req, // Reset request, async
  input  wire            watchdog_halt_option, // Option: halt gives no watchdog reset
  input  wire            pll_enable,    // PLL option
  input  wire            irq_done,      // Vector fetch done by CPU
  output reg             cpu_clk_en,    // CPU clock gate
  output reg             periph_clk_en, // Peripheral clock gate
  output reg             osc_run,       // Main oscillator on
  output reg             timer_run,     // Wake timebase counter clocked
  output reg             pll_out_en,    // PLL clock released
  output reg  [5:0]      clk_div,       // Master clock divider
  output reg             mask_clear,    // Clear condition_code_reg mask, pulse
  output reg             wake_irq,      // Service waking interrupt, pulse
  output reg             fetch_reset,   // Fetch reset vector, pulse
  output reg             wdg_reset,     // Watchdog reset request, pulse
  output reg             awu_active     // Timed auto-wake halt running
);
  localparam [6:0] S_RUN  = 7'h01;
  localparam [6:0] S_WAIT = 7'h02;
  localparam [6:0] S_HALT = 7'h04;
  localparam [6:0] S_AHLT = 7'h08;
  localparam [6:0] S_AWU  = 7'h10;
  localparam [6:0] S_STAB = 7'h20;
  localparam [6:0] S_PLL  = 7'h40;
  localparam integer PLL_CYC = (`PSMC_PLL_START_NS * `PSMC_CLK_MHZ + 999) / 1000;

  reg [NIRQ-1:0] irq_s1_q, irq_s2_q;
  reg            rst_s1_q, rst_s2_q;
  reg [7:0]      ctrl_q;
  reg [NIRQ-1:0] hcap_q, acap_q;
  reg [6:0]      state_q;
  reg [12:0]     cnt_q;
  reg            by_reset_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_q <= {NIRQ{1'b0}};
      irq_s2_q <= {NIRQ{1'b0}};
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else if (clk_en) begin
      irq_s1_q <= irq_pend;
      irq_s2_q <= irq_s1_q;
      rst_s1_q <= ext_reset_req;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire ahalt_en = ctrl_q[`PSMC_CTRL_TIMEBASE1_IRQ_ENABLE] |
                  (ctrl_q[`PSMC_CTRL_OVERFLOW_IRQ_ENABLE] & ~ctrl_q[`PSMC_CTRL_ATBIT0] &
                   ctrl_q[`PSMC_CTRL_CK0]);
  wire hwake = |(irq_s2_q & hcap_q);
  wire awake = |(irq_s2_q & acap_q);
  wire anyirq = |irq_s2_q;
  wire [12:0] stab_cyc = ctrl_q[`PSMC_CTRL_LONGDLY] ? STAB_LONG[12:0] - 13'h0001
                                                    : STAB_SHORT[12:0] - 13'h0001;

  // APB: zero wait states, unmapped reads zero with error
  wire acc = psel & penable;
  wire hit = (paddr == `PSMC_ADDR_CTRL) | (paddr == `PSMC_ADDR_STATUS) |
             (paddr == `PSMC_ADDR_CMD) | (paddr == `PSMC_ADDR_HCAP) |
             (paddr == `PSMC_ADDR_ACAP);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  wire wr = acc & pwrite & clk_en;
  wire sw_wait = wr & (paddr == `PSMC_ADDR_CMD) & pwdata[`PSMC_CMD_WAIT];
  wire sw_halt = wr & (paddr == `PSMC_ADDR_CMD) & pwdata[`PSMC_CMD_HALT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      hcap_q <= `PSMC_HCAP_RST;
      acap_q <= `PSMC_ACAP_RST;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr && paddr == `PSMC_ADDR_CTRL)
        ctrl_q <= pwdata[7:0];
      if (wr && paddr == `PSMC_ADDR_HCAP)
        hcap_q <= pwdata[NIRQ-1:0];
      if (wr && paddr == `PSMC_ADDR_ACAP)
        acap_q <= pwdata[NIRQ-1:0];
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `PSMC_ADDR_CTRL:   prdata <= {24'h000000, ctrl_q};
          `PSMC_ADDR_STATUS: prdata <= {18'h00000, cnt_q == 13'h0000, state_q, clk_div};
          `PSMC_ADDR_HCAP:   prdata <= {{(32-NIRQ){1'b0}}, hcap_q};
          `PSMC_ADDR_ACAP:   prdata <= {{(32-NIRQ){1'b0}}, acap_q};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire go_wait = wait_for_irq_instruction | sw_wait;
  wire go_halt = halt_instr | sw_halt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= S_RUN;
      cnt_q       <= 13'h0000;
      by_reset_q  <= 1'b0;
      mask_clear  <= 1'b0;
      wake_irq    <= 1'b0;
      fetch_reset <= 1'b0;
      wdg_reset   <= 1'b0;
    end else if (clk_en) begin
      mask_clear  <= 1'b0;
      wake_irq    <= 1'b0;
      fetch_reset <= 1'b0;
      wdg_reset   <= 1'b0;
      case (state_q)
        S_RUN: begin
          if (go_halt) begin
            mask_clear <= 1'b1;
            if (ahalt_en) begin
              state_q <= S_AHLT;
            end else if (ctrl_q[`PSMC_CTRL_AWEN]) begin
              state_q <= S_AWU;
            end else if (ctrl_q[`PSMC_CTRL_WDGEN] && !watchdog_halt_option) begin
              wdg_reset <= 1'b1;
              by_reset_q <= 1'b1;
              cnt_q <= stab_cyc;
              state_q <= S_STAB;
            end else begin
              state_q <= S_HALT;
            end
          end else if (go_wait) begin
            mask_clear <= 1'b1;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (rst_s2_q) begin
            fetch_reset <= 1'b1;
            state_q <= S_RUN;
          end else if (anyirq) begin
            wake_irq <= 1'b1;
            state_q <= S_RUN;
          end
        end
        S_HALT, S_AWU: begin
          if (rst_s2_q || hwake) begin
            by_reset_q <= rst_s2_q;
            cnt_q <= stab_cyc;
            state_q <= S_STAB;
          end
        end
        S_AHLT: begin
          if (rst_s2_q) begin
            by_reset_q <= 1'b1;
            cnt_q <= stab_cyc;
            state_q <= S_STAB;
          end else if (awake) begin
            wake_irq <= 1'b1;
            state_q <= S_RUN;
          end
        end
        S_STAB: begin
          if (cnt_q != 13'h0000) begin
            cnt_q <= cnt_q - 13'h0001;
          end else if (pll_enable) begin
            cnt_q <= PLL_CYC[12:0];
            state_q <= S_PLL;
          end else begin
            fetch_reset <= by_reset_q;
            wake_irq <= ~by_reset_q;
            by_reset_q <= 1'b0;
            state_q <= S_RUN;
          end
        end
        S_PLL: begin
          if (cnt_q != 13'h0000) begin
            cnt_q <= cnt_q - 13'h0001;
          end else begin
            fetch_reset <= by_reset_q;
            wake_irq <= ~by_reset_q;
            by_reset_q <= 1'b0;
            state_q <= S_RUN;
          end
        end
        default: state_q <= S_RUN;
      endcase
    end
  end

  // Clock gating follows the state
  always @* begin
    cpu_clk_en    = (state_q == S_RUN);
    periph_clk_en = (state_q == S_RUN) | (state_q == S_WAIT);
    osc_run       = ~((state_q == S_HALT) | (state_q == S_AWU));
    timer_run     = osc_run & ~(state_q == S_STAB) & ~(state_q == S_PLL);
    pll_out_en    = ~pll_enable | (state_q == S_RUN) | (state_q == S_WAIT) |
                    (state_q == S_AHLT);
    clk_div       = ctrl_q[`PSMC_CTRL_SLOW] ? 6'd`PSMC_SLOW_DIV
                                            : 6'd`PSMC_FAST_DIV;
    awu_active    = (state_q == S_AWU);
  end
endmodule // psmc_ctrl
`default_nettype wire

// [test/psmc_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module psmc_ctrl_properties (
  input wire logic        pclk, presetn, clk_en, psel, penable, pslverr, // Bus side
  input wire logic [11:0] paddr,                                        // Bus address
  input wire logic        wait_for_irq_instruction, halt_instr,         // CPU requests
  input wire logic        cpu_clk_en, periph_clk_en, osc_run,           // Clock gates
  input wire logic [5:0]  clk_div,                                      // Divider
  input wire logic        mask_clear, wake_irq, fetch_reset, wdg_reset  // Pulses
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic run = cpu_clk_en & clk_en;
  property p_boot; $rose(presetn) |-> cpu_clk_en && clk_div == 6'd1; endproperty
  a_boot: assert property (p_boot) else $error("not in run after reset");
  property p_div; clk_div == 6'd1 || clk_div == 6'd32; endproperty
  a_div: assert property (p_div) else $error("bad divider");
  property p_wait; wait_for_irq_instruction && run && !halt_instr
    |=> mask_clear && !cpu_clk_en && periph_clk_en; endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");
  property p_halt; halt_instr && run && !wait_for_irq_instruction
    |=> (mask_clear || wdg_reset) && !cpu_clk_en; endproperty
  a_halt: assert property (p_halt) else $error("halt entry wrong");
  property p_osc; !osc_run |-> !cpu_clk_en && !periph_clk_en; endproperty
  a_osc: assert property (p_osc) else $error("clock runs with oscillator off");
  // Bench sets the short stabilisation count to 8
  property p_stab; $rose(osc_run) |-> !cpu_clk_en [*8]; endproperty
  a_stab: assert property (p_stab) else $error("stabilisation too short");
  property p_err; psel && penable && paddr > 12'h010 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_wake; wake_irq |-> ##[0:1] cpu_clk_en; endproperty
  a_wake: assert property (p_wake) else $error("cpu not resumed on wake");
  property p_wdg; wdg_reset |-> ##[1:60] fetch_reset; endproperty
  a_wdg: assert property (p_wdg) else $error("no vector after watchdog");
endmodule // psmc_ctrl_properties
bind psmc_ctrl psmc_ctrl_properties i_psmc_ctrl_properties (.pclk, .presetn, .clk_en, .psel,
  .penable, .pslverr, .paddr, .wait_for_irq_instruction, .halt_instr, .cpu_clk_en,
  .periph_clk_en, .osc_run, .clk_div, .mask_clear, .wake_irq, .fetch_reset, .wdg_reset);
`default_nettype wire

// [test/psmc_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psmc_cpu_model (
  input wire logic        pclk, presetn, rq_w, rq_h, rq_r, // Clock, reset, requests
  input wire logic [13:0] iset,                            // Sources to raise
  input wire logic        wake_irq, fetch_reset,           // Core answers
  output logic            wait_for_irq_instruction, halt_instr, ext_reset_req, irq_done,
  output logic [13:0]     irq_pend                          // Latched sources
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {wait_for_irq_instruction, halt_instr, ext_reset_req, irq_done} <= 4'h0;
      irq_pend <= 14'h0;
    end else begin
      wait_for_irq_instruction <= rq_w;
      halt_instr <= rq_h;
      irq_done <= wake_irq;
      irq_pend <= (wake_irq | fetch_reset) ? 14'h0 : irq_pend | iset;
      ext_reset_req <= fetch_reset ? 1'b0 : ext_reset_req | rq_r;
    end
  end
endmodule // psmc_cpu_model
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psmc_consts.vh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rq_w = 0, rq_h = 0;
  logic rq_r = 0, watchdog_halt_option = 0, er, wseen = 0, wclr = 0;
  logic pll_enable = 0, clk_en = 1;
  wire logic pll_out_en;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [13:0] iset = 0;
  logic [39:0] cv = 40'h2008382804;
  logic [4:0]  av = 5'b00011;
  wire logic pready, pslverr, wait_for_irq_instruction, halt_instr, ext_reset_req, irq_done;
  wire logic cpu_clk_en, periph_clk_en, osc_run, timer_run, mask_clear, wake_irq;
  wire logic fetch_reset, wdg_reset, awu_active;
  wire logic [31:0] prdata;
  wire logic [5:0]  clk_div;
  wire logic [13:0] irq_pend;
  int n_errors = 0, check_count = 0, cyc = 0, n, i;
  always #5 pclk = ~pclk;
  always @(posedge pclk) wseen <= wdg_reset | (wseen & ~wclr);
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  psmc_cpu_model i_psmc_cpu_model (.pclk, .presetn, .rq_w, .rq_h, .rq_r, .iset, .wake_irq,
    .fetch_reset, .wait_for_irq_instruction, .halt_instr, .ext_reset_req, .irq_done, .irq_pend);
  psmc_ctrl #(.STAB_LONG(16), .STAB_SHORT(8)) i_psmc_ctrl (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .wait_for_irq_instruction, .halt_instr, .irq_pend, .ext_reset_req, .watchdog_halt_option,
    .pll_enable, .irq_done, .cpu_clk_en, .periph_clk_en, .osc_run, .timer_run,
    .pll_out_en, .clk_div, .mask_clear, .wake_irq, .fetch_reset, .wdg_reset, .awu_active);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // Let register writes settle before callers look at outputs
    @(negedge pclk);
  endtask
  task ins(input logic w, input logic h);
    @(posedge pclk);
    {rq_w, rq_h} <= {w, h};
    @(posedge pclk);
    {rq_w, rq_h} <= 2'b00;
    repeat (4) @(posedge pclk);
  endtask
  task irq(input logic [13:0] v);
    @(posedge pclk);
    iset <= v;
    @(posedge pclk);
    iset <= 14'h0;
  endtask
  task wev(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1 n++;
    end while (wake_irq !== 1'b1 && fetch_reset !== 1'b1 && n < lim);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, `PSMC_ADDR_HCAP, 0);
    chk(rd, 32'h101f);
    apb(0, `PSMC_ADDR_ACAP, 0);
    chk(rd, 32'h0a00);
    apb(0, `PSMC_ADDR_STATUS, 0);
    chk(rd[12:0], 32'h41);
    apb(0, 12'h040, 0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1, `PSMC_ADDR_CTRL, 32'h1);
    chk(clk_div, 32);
    ins(1, 0);
    chk({cpu_clk_en, periph_clk_en, clk_div}, {2'b01, 6'd32});
    irq(14'h0020);
    wev(300);
    chk(wake_irq, 1);
    apb(1, `PSMC_ADDR_CTRL, 32'h0);
    chk(clk_div, 1);
    for (i = 0; i < 5; i++) begin
      apb(1, `PSMC_ADDR_CTRL, {24'h0, cv[8*i+:8]});
      ins(0, 1);
      chk({osc_run, timer_run, cpu_clk_en}, {av[i], av[i], 1'b0});
      irq(14'h0020);
      wev(20);
      chk(n, 20);
      irq(av[i] ? 14'h0800 : 14'h0002);
      wev(300);
      chk({wake_irq, av[i] ? n <= 4 : n >= 8}, 2'b11);
    end
    apb(1, `PSMC_ADDR_CTRL, 32'h4);
    ins(0, 1);
    @(posedge pclk) rq_r <= 1;
    @(posedge pclk) rq_r <= 0;
    wev(300);
    chk({fetch_reset, n >= 8}, 2'b11);
    for (i = 0; i < 3; i++) begin
      watchdog_halt_option <= (i == 1);
      apb(1, `PSMC_ADDR_CTRL, i == 2 ? 32'h44 : 32'h40);
      @(posedge pclk) wclr <= 1;
      @(posedge pclk) wclr <= 0;
      ins(0, 1);
      irq(14'h0802);
      wev(300);
      chk(wseen, i == 0);
    end
    apb(1, `PSMC_ADDR_CTRL, 32'h2);
    ins(0, 1);
    chk({awu_active, osc_run}, 2'b10);
    irq(14'h0002);
    wev(300);
    chk(wake_irq, 1);
    @(posedge pclk) clk_en <= 0;
    apb(1, `PSMC_ADDR_CTRL, 32'h1);
    chk(clk_div, 1);
    @(posedge pclk) clk_en <= 1;
    pll_enable <= 1;
    apb(1, `PSMC_ADDR_CTRL, 32'h0);
    ins(0, 1);
    chk({pll_out_en, osc_run}, 2'b00);
    irq(14'h0002);
    wev(300);
    chk({wake_irq, n >= 108}, 2'b11);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
